// file: hw/slse_encoder.sv
// one serial lane: raw word build, scramble, clock bit, disparity, sync
// Notes on behaviour
// - raw word is 12-bit sample plus two control bits chosen by config
// - additive scrambling with x^17+x^3+1, fourteen steps per frame
// - next bits 0..2 take old 14..16; bit i is old i-3 xor old i
// - raw word xored with the 14 low generator bits
// - clock bit appended and inverted every coded frame; alignment frames leave it alone
// - frame is 14 data bits, clock bit and disparity bit
// - within +/-15 running disparity: send as is, disparity bit clear
// - beyond +/-15: invert fifteen bits, set disparity bit
// - running disparity kept per lane, updated with frame actually sent
// - sync pulse in sync mode starts two-step sequence
// - step one: 32 frames alternating FF00 and 00FF, no processing
// - step two: 32 generator frames with disparity, then data
// - generator reset on each sync pulse in sync mode
// - disparity bit is frame bit 15; set means others inverted
// - in trigger mode pulses do not start link sync
`timescale 1ns/1ps
`default_nettype none
module slse_encoder #(
	parameter logic [16:0] SEED = slse_pkg::LFSR_SEED,
	parameter int          FIFO_DEPTH = slse_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_SYS_RST,
	// sample input stream
	input  wire logic        I_SAMPLE_VALID,
	input  wire logic [11:0] I_SAMPLE,
	output logic             O_SAMPLE_READY,
	// lane pair control bit configuration
	input  wire logic [1:0]  I_LANE_PAIR_CONFIG_FIRST,
	input  wire logic [1:0]  I_LANE_PAIR_CONFIG_SECOND,
	input  wire logic        I_AUX_CONTROL_BIT_FIRST,
	input  wire logic        I_AUX_CONTROL_BIT_SECOND,
	// sync control
	input  wire logic        I_SYNC_MODE,
	input  wire logic        I_SYNC_TRIGGER_PULSE,
	// frame clock enable and output
	input  wire logic        I_FRAME_EN,
	output logic [15:0]      O_FRAME,
	output logic             O_FRAME_VALID,
	output logic             O_SYNC_BUSY
);
	localparam int RW = slse_pkg::RAW_W;

	// select one control bit source from a two-bit config field
	function automatic logic sel_cb(input logic [1:0] cfg, input logic aux);
		case (cfg)
			slse_pkg::CFG_SEL_BIT1: sel_cb = aux;
			slse_pkg::CFG_SEL_BIT2: sel_cb = ~aux;
			slse_pkg::CFG_SEL_ONE:  sel_cb = 1'b1;
			default:                sel_cb = 1'b0;
		endcase
	endfunction : sel_cb

	// signed ones minus zeros over fifteen bits
	function automatic logic signed [6:0] disp15(input logic [14:0] w);
		logic signed [6:0] acc;
		acc = -7'sd15;
		for (int k = 0; k < 15; k++) acc = acc + (w[k] ? 7'sd2 : 7'sd0);
		return acc;
	endfunction : disp15

	// fourteen-step advance of the generator
	function automatic logic [16:0] lfsr_next(input logic [16:0] s);
		logic [16:0] n;
		n[2:0] = s[16:14];
		for (int k = 3; k < 17; k++) n[k] = s[k-3] ^ s[k];
		return n;
	endfunction : lfsr_next

	slse_fifo_if #(.WIDTH(RW)) fq ();

	wire cb_one = sel_cb(I_LANE_PAIR_CONFIG_FIRST, I_AUX_CONTROL_BIT_FIRST);
	wire cb_two = sel_cb(I_LANE_PAIR_CONFIG_SECOND, I_AUX_CONTROL_BIT_SECOND);
	// control bits sit above the sample
	wire [RW-1:0] raw_in = {cb_two, cb_one, I_SAMPLE};

	slse_fifo #(.WIDTH(RW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk   (I_SYS_CLK),
		.i_rst   (I_SYS_RST),
		.i_valid (I_SAMPLE_VALID),
		.i_data  (raw_in),
		.o_ready (O_SAMPLE_READY),
		.rd      (fq.src)
	);

	slse_pkg::slse_state_type state;
	slse_pkg::slse_state_type next_state;
	logic [16:0]        lfsr;
	logic [5:0]         seq_cnt;
	logic               clk_bit;
	logic signed [6:0]  run_disp;

	// trigger mode blocks sync
	wire sync_start = I_SYNC_TRIGGER_PULSE && I_SYNC_MODE;
	wire seq_end    = (seq_cnt == slse_pkg::SEQ_LAST);
	// data frames wait for a sample; underflow sends nothing
	wire in_data    = (state == slse_pkg::SLSE_ST_DATA);
	wire take       = I_FRAME_EN && !sync_start && in_data && fq.valid;
	assign fq.ready = take;

	wire [RW-1:0] scr   = fq.data ^ lfsr[RW-1:0];
	// seeding frames carry generator bits and the clock bit
	wire [RW-1:0] word  = (state == slse_pkg::SLSE_ST_SEED) ? lfsr[RW-1:0]
		: scr;
	wire [14:0]   pre   = {clk_bit, word};
	wire signed [6:0] d_pre = disp15(pre);
	wire signed [6:0] sum_pre = run_disp + d_pre;
	wire          flip  = (sum_pre > slse_pkg::DISP_LIMIT) ||
		(sum_pre < -slse_pkg::DISP_LIMIT);
	wire [14:0]   sent  = flip ? ~pre : pre;
	wire [15:0]   enc   = {flip, sent};
	wire [15:0]   comma = seq_cnt[0] ? slse_pkg::COMMA_B : slse_pkg::COMMA_A;
	wire          step  = I_FRAME_EN && !sync_start;
	wire          emit_coded = step &&
		((state == slse_pkg::SLSE_ST_SEED) || take);

	always_comb begin
		next_state = state;
		case (state)
			slse_pkg::SLSE_ST_IDLE:  next_state = state;
			slse_pkg::SLSE_ST_COMMA:
				if (step && seq_end) next_state = slse_pkg::SLSE_ST_SEED;
			slse_pkg::SLSE_ST_SEED:
				if (step && seq_end) next_state = slse_pkg::SLSE_ST_DATA;
			slse_pkg::SLSE_ST_DATA:  next_state = state;
			default:                 next_state = slse_pkg::SLSE_ST_IDLE;
		endcase
		if (sync_start) next_state = slse_pkg::SLSE_ST_COMMA;
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			state   <= slse_pkg::SLSE_ST_IDLE;
			seq_cnt <= slse_pkg::CNT_ZERO;
		end else begin
			state <= next_state;
			if (sync_start) seq_cnt <= slse_pkg::CNT_ZERO;
			else if (step && state != slse_pkg::SLSE_ST_DATA)
				seq_cnt <= seq_end ? slse_pkg::CNT_ZERO
					: seq_cnt + 6'h01;
		end
	end

	// generator held during commas so step two opens on the seed
	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) lfsr <= SEED;
		else if (sync_start) lfsr <= SEED;
		else if (emit_coded) lfsr <= lfsr_next(lfsr);
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST || sync_start) begin
			clk_bit  <= 1'b0;
			run_disp <= '0;
		end else if (emit_coded) begin
			clk_bit  <= ~clk_bit;
			run_disp <= flip ? run_disp - d_pre : sum_pre;
		end
	end

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST) begin
			O_FRAME       <= 16'h0000;
			O_FRAME_VALID <= 1'b0;
		end else begin
			O_FRAME_VALID <= 1'b0;
			if (step && state == slse_pkg::SLSE_ST_COMMA) begin
				O_FRAME       <= comma;
				O_FRAME_VALID <= 1'b1;
			end else if (emit_coded) begin
				O_FRAME       <= enc;
				O_FRAME_VALID <= 1'b1;
			end
		end
	end

	assign O_SYNC_BUSY = (state == slse_pkg::SLSE_ST_COMMA) ||
		(state == slse_pkg::SLSE_ST_SEED);

	// helper counters below only watch the sequence; nothing reads them
	// back into the datapath, so they cost nothing in a real build
	localparam logic [6:0] SEQ_LEN = 7'(slse_pkg::SEQ_FRAMES);
	logic [6:0] comma_seen;
	logic [6:0] seed_seen;
	wire        comma_frame = step && (state == slse_pkg::SLSE_ST_COMMA);
	wire        seed_frame  = step && (state == slse_pkg::SLSE_ST_SEED);
	wire        empty_step  = step && in_data && !fq.valid;

	always_ff @(posedge I_SYS_CLK) begin
		if (I_SYS_RST || sync_start) begin
			comma_seen <= '0;
			seed_seen  <= '0;
		end else begin
			if (comma_frame) comma_seen <= comma_seen + 7'h01;
			if (seed_frame) seed_seen <= seed_seen + 7'h01;
		end
	end

	// checks
	sequence s_sync_hit;
		sync_start;
	endsequence
	sequence s_comma_on;
		state == slse_pkg::SLSE_ST_COMMA && seq_cnt == slse_pkg::CNT_ZERO;
	endsequence
	sequence s_comma_end;
		comma_frame && seq_end;
	endsequence
	sequence s_seed_end;
		seed_frame && seq_end;
	endsequence
	// entry into data is seen one edge after the last seed frame
	sequence s_data_entry;
		state == slse_pkg::SLSE_ST_DATA &&
		$past(state) == slse_pkg::SLSE_ST_SEED;
	endsequence

	a_sync_starts_seq : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) s_sync_hit |=> s_comma_on)
		else $error("sync pulse did not start sequence");
	a_trig_mode_block : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST)
		(I_SYNC_TRIGGER_PULSE && !I_SYNC_MODE && !O_SYNC_BUSY) |=>
		!O_SYNC_BUSY)
		else $error("trigger mode started sync");
	a_lfsr_reseed : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) sync_start |=> lfsr == SEED)
		else $error("generator not reset on sync");
	a_lfsr_step : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) emit_coded |=>
		lfsr[2:0] == $past(lfsr[16:14]) &&
		lfsr[16:3] == ($past(lfsr[13:0]) ^ $past(lfsr[16:3])))
		else $error("generator step wrong");
	a_comma_pattern : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST)
		(step && state == slse_pkg::SLSE_ST_COMMA) |=>
		(O_FRAME == slse_pkg::COMMA_A || O_FRAME == slse_pkg::COMMA_B))
		else $error("alignment frame wrong");
	a_disp_bounded : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) run_disp <= slse_pkg::DISP_LIMIT &&
		run_disp >= -slse_pkg::DISP_LIMIT)
		else $error("running disparity out of range");
	a_flip_inverts : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) (emit_coded && !sync_start) |=>
		O_FRAME[14:0] == (O_FRAME[15] ? ~$past(pre) : $past(pre)))
		else $error("disparity bit and inversion disagree");
	a_clk_toggles : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) (emit_coded && !sync_start) |=>
		clk_bit != $past(clk_bit))
		else $error("clock bit did not toggle");
	a_scramble_xor : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) take |=>
		(O_FRAME[13:0] ^ {14{O_FRAME[15]}}) ==
		($past(fq.data) ^ $past(lfsr[13:0])))
		else $error("scrambled word wrong");

	// a_seq_lengths and the comma parity checks below lean on the helper counters, not on seq_cnt,
	// so a slip in that counter shows up as a length error
	a_comma_to_seed : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) s_comma_end |=>
		state == slse_pkg::SLSE_ST_SEED && seq_cnt == slse_pkg::CNT_ZERO)
		else $error("seeding step did not follow alignment");
	a_seed_to_data : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) s_seed_end |=>
		state == slse_pkg::SLSE_ST_DATA && !O_SYNC_BUSY)
		else $error("data did not follow seeding");
	a_seq_lengths : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) s_data_entry |->
		comma_seen == SEQ_LEN && seed_seen == SEQ_LEN)
		else $error("sync step length wrong");
	a_seq_cnt_range : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) O_SYNC_BUSY |->
		seq_cnt <= slse_pkg::SEQ_LAST)
		else $error("sequence counter left its range");
	a_comma_even : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) (comma_frame && !comma_seen[0]) |=>
		O_FRAME == slse_pkg::COMMA_A)
		else $error("even alignment frame wrong");
	a_comma_odd : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) (comma_frame && comma_seen[0]) |=>
		O_FRAME == slse_pkg::COMMA_B)
		else $error("odd alignment frame wrong");
	a_comma_bypass : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) comma_frame |=>
		lfsr == $past(lfsr) && run_disp == $past(run_disp) &&
		clk_bit == $past(clk_bit))
		else $error("alignment frame touched coder state");
	a_seed_word : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) seed_frame |=>
		(O_FRAME[13:0] ^ {14{O_FRAME[15]}}) == $past(lfsr[13:0]))
		else $error("seeding frame does not carry generator");
	a_seed_first : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) (seed_frame && seed_seen == '0) |->
		lfsr == SEED)
		else $error("first seeding frame not from seed");
	a_data_steady : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) (in_data && !sync_start) |=> in_data)
		else $error("data mode left without sync");
	a_run_update : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) emit_coded |=>
		run_disp == $past(run_disp) + disp15(O_FRAME[14:0]))
		else $error("running disparity not from sent frame");
	a_keep_plain : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) (emit_coded &&
		sum_pre <= slse_pkg::DISP_LIMIT &&
		sum_pre >= -slse_pkg::DISP_LIMIT) |=> !O_FRAME[15])
		else $error("frame inverted without need");
	a_sync_clears : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) sync_start |=>
		clk_bit == 1'b0 && run_disp == 7'sd0)
		else $error("clock bit or disparity not cleared on sync");
	a_clk_in_frame : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) emit_coded |=>
		O_FRAME[14] == ($past(clk_bit) ^ O_FRAME[15]))
		else $error("clock bit not at its place");
	a_idle_silent : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) state == slse_pkg::SLSE_ST_IDLE |=>
		!O_FRAME_VALID)
		else $error("frame sent before any sync");
	// an empty buffer must not burn generator or clock bit states
	a_empty_hold : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) empty_step |=>
		!O_FRAME_VALID && lfsr == $past(lfsr) &&
		clk_bit == $past(clk_bit))
		else $error("empty buffer still sent a frame");
	a_frame_hold : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) !step |=>
		O_FRAME == $past(O_FRAME) && !O_FRAME_VALID)
		else $error("frame changed without frame enable");
	a_valid_cause : assert property (@(posedge I_SYS_CLK)
		disable iff (I_SYS_RST) O_FRAME_VALID |-> $past(step))
		else $error("frame valid without frame enable");
endmodule : slse_encoder
`default_nettype wire

// file: hw/slse_pkg.sv
// constants and types shared by the lane scrambler encoder
package slse_pkg;
	localparam int SAMPLE_W = 12;
	localparam int RAW_W = 14;
	localparam int LFSR_W = 17;
	localparam int FRAME_W = 16;
	localparam int CLK_BIT = 14;
	localparam int DISP_BIT = 15;
	localparam int SEQ_FRAMES = 32;
	localparam int FIFO_DEPTH = 32;
	localparam logic [16:0] LFSR_SEED = 17'h1FFFF;
	localparam logic [15:0] COMMA_A = 16'hFF00;
	localparam logic [15:0] COMMA_B = 16'h00FF;
	localparam logic signed [6:0] DISP_LIMIT = 7'sd15;
	localparam logic [5:0] SEQ_LAST = 6'h1F;
	localparam logic [5:0] CNT_ZERO = 6'h00;
	localparam logic [1:0] CFG_SEL_BIT1 = 2'h1;
	localparam logic [1:0] CFG_SEL_BIT2 = 2'h2;
	localparam logic [1:0] CFG_SEL_ONE = 2'h3;

	typedef enum logic [1:0] {
		SLSE_ST_IDLE  = 2'b00,
		SLSE_ST_COMMA = 2'b01,
		SLSE_ST_SEED  = 2'b11,
		SLSE_ST_DATA  = 2'b10
	} slse_state_type;
endpackage : slse_pkg

// file: hw/slse_fifo_if.sv
// valid and ready link between sample source and encoder
`timescale 1ns/1ps
`default_nettype none
interface slse_fifo_if #(parameter int WIDTH = 14);
	logic             valid;
	logic             ready;
	logic [WIDTH-1:0] data;
	modport src  (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface : slse_fifo_if
`default_nettype wire

// file: hw/slse_fifo.sv
// synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module slse_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 32
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	// write side
	input  wire logic             i_valid,
	input  wire logic [WIDTH-1:0] i_data,
	output logic                  o_ready,
	// read side
	slse_fifo_if.src              rd
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	wire              do_wr = i_valid && o_ready;
	wire              do_rd = rd.valid && rd.ready;

	assign o_ready  = (count != (AW+1)'(DEPTH));
	assign rd.valid = (count != '0);
	assign rd.data  = mem[rd_ptr];

	always_ff @(posedge i_clk) begin
		if (do_wr) mem[wr_ptr] <= i_data;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (do_wr) wr_ptr <= AW'((wr_ptr + 1'b1) % DEPTH);
			if (do_rd) rd_ptr <= AW'((rd_ptr + 1'b1) % DEPTH);
			count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
		end
	end

	a_fifo_no_over : assert property (@(posedge i_clk) disable iff (i_rst)
		count <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule : slse_fifo
`default_nettype wire

// file: testbench/slse_rx_model.sv
// receiver model: comma alignment, generator rebuild, descrambling
`timescale 1ns/1ps
`default_nettype none
module slse_rx_model (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// encoded lane
	input  wire logic [15:0] i_frame,
	input  wire logic        i_frame_valid,
	// sync request, decoded word, clock bit monitor
	output var logic         o_sync,
	output var logic [13:0]  o_word,
	output var logic         o_clk_err
);
	logic [16:0] lf;
	logic [13:0] s1;
	logic [5:0]  cnt;
	logic        pclk;
	logic [14:0] w;
	function automatic logic [16:0] nx(input logic [16:0] s);
		return {s[13:0] ^ s[16:3], s[16:14]};
	endfunction : nx
	assign w = i_frame[15] ? ~i_frame[14:0] : i_frame[14:0];
	initial o_sync = 1'b0;
	// one cycle wide, launched just after the edge
	task automatic pulse_sync;
		@(posedge i_clk);
		#1 o_sync = 1'b1;
		@(posedge i_clk);
		#1 o_sync = 1'b0;
	endtask : pulse_sync
	// two seed frames give the whole generator state
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt <= 6'h00;
			o_clk_err <= 1'b0;
		end else if (i_frame_valid) begin
			pclk <= w[14];
			lf <= nx(lf);
			if (i_frame == 16'hFF00 || i_frame == 16'h00FF) begin
				cnt <= 6'h00;
			end else if (cnt == 6'h00) begin
				s1 <= w[13:0];
				cnt <= 6'h01;
			end else if (cnt == 6'h01) begin
				lf <= nx(nx({w[2:0], s1}));
				cnt <= 6'h02;
			end else if (cnt != 6'h20) begin
				cnt <= cnt + 6'h01;
			end else begin
				o_word <= w[13:0] ^ lf[13:0];
				o_clk_err <= o_clk_err | (w[14] == pclk);
			end
		end
	end
endmodule : slse_rx_model
`default_nettype wire

// file: testbench/slse_encoder_test.sv
// self-checking bench for the lane scrambler encoder
`timescale 1ns/1ps
`default_nettype none
module slse_encoder_test;
	localparam logic [16:0] SEED_VAL = 17'h0ACE1;
	logic        clk, rst, valid, en, mode, aux1, aux2, sync, fv, busy;
	logic        rdy, cerr, clkb;
	logic [11:0] smp;
	logic [1:0]  cf1, cf2;
	logic [15:0] frm, e;
	logic [13:0] word;
	logic [16:0] lf;
	logic [13:0] q[$];
	int          run, n_errors, checked;
	slse_encoder #(.SEED(SEED_VAL)) DUT (.I_SYS_CLK(clk), .I_SYS_RST(rst),
		.I_SAMPLE_VALID(valid), .I_SAMPLE(smp), .O_SAMPLE_READY(rdy),
		.I_LANE_PAIR_CONFIG_FIRST(cf1), .I_LANE_PAIR_CONFIG_SECOND(cf2),
		.I_AUX_CONTROL_BIT_FIRST(aux1), .I_AUX_CONTROL_BIT_SECOND(aux2),
		.I_SYNC_MODE(mode), .I_SYNC_TRIGGER_PULSE(sync), .I_FRAME_EN(en),
		.O_FRAME(frm), .O_FRAME_VALID(fv), .O_SYNC_BUSY(busy));
	slse_rx_model rx (.i_clk(clk), .i_rst(rst), .i_frame(frm),
		.i_frame_valid(fv), .o_sync(sync), .o_word(word), .o_clk_err(cerr));
	function automatic logic [16:0] nx(input logic [16:0] s);
		return {s[13:0] ^ s[16:3], s[16:14]};
	endfunction : nx
	function automatic logic cb(input logic [1:0] c, input logic a);
		return c == 2'h0 ? 1'b0 : c == 2'h1 ? a : c == 2'h2 ? ~a : 1'b1;
	endfunction : cb
	task automatic chk(input string nm, input logic [15:0] s, x);
		checked++;
		if (s !== x) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, x, s);
		end
	endtask : chk
	task end_of_test;
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_of_test
	// reference coder; disparity bit is left out of the running sum
	task automatic ref_enc(input logic [13:0] raw, output logic [15:0] f);
		logic [14:0] w;
		int d;
		w = {clkb, raw ^ lf[13:0]};
		d = 2 * $countones(w) - 15;
		if (run + d > 15 || run + d < -15) begin
			f = {1'b1, ~w};
			run -= d;
		end else begin
			f = {1'b0, w};
			run += d;
		end
		clkb = ~clkb;
		lf = nx(lf);
	endtask : ref_enc
	task automatic step(input logic v, input logic [15:0] x);
		@(posedge clk);
		#1 en = 1'b1;
		@(posedge clk);
		#1 en = 1'b0;
		chk("frame_valid", {15'h0, fv}, {15'h0, v});
		if (v) chk("frame", frm, x);
	endtask : step
	task automatic push(input logic [11:0] s, input logic a);
		@(posedge clk);
		#1 valid = 1'b1;
		smp = s;
		aux1 = a;
		aux2 = ~a;
		@(posedge clk);
		#1 valid = 1'b0;
	endtask : push
	task automatic data(input logic [13:0] raw);
		ref_enc(raw, e);
		step(1'b1, e);
		@(posedge clk);
		#1 chk("decoded", {2'h0, word}, {2'h0, raw});
	endtask : data
	task automatic t_sync;
		rx.pulse_sync();
		chk("busy", {15'h0, busy}, 16'h1);
		lf = SEED_VAL;
		clkb = 1'b0;
		run = 0;
		for (int i = 0; i < 32; i++) step(1'b1, i[0] ? 16'h00FF : 16'hFF00);
		for (int i = 0; i < 32; i++) begin
			ref_enc(14'h0, e);
			step(1'b1, e);
		end
		chk("busy", {15'h0, busy}, 16'h0);
		$display("test sync done");
	endtask : t_sync
	// far side stalls while the buffer fills; samples push disparity hard
	task automatic t_fill;
		logic [16:0] tmp;
		logic [11:0] s;
		tmp = lf;
		cf1 = 2'h1;
		cf2 = 2'h2;
		for (int i = 0; i < 32; i++) begin
			s = i[1] ? ~tmp[11:0] : tmp[11:0];
			chk("ready", {15'h0, rdy}, 16'h1);
			push(s, i[2]);
			q.push_back({i[2], i[2], s});
			tmp = nx(tmp);
		end
		chk("ready", {15'h0, rdy}, 16'h0);
		push(12'hABC, 1'b0);
		for (int i = 0; i < 32; i++) data(q.pop_front());
		step(1'b0, 16'h0);
		$display("test fill done");
	endtask : t_fill
	task automatic t_cfg;
		for (int c = 0; c < 4; c++) begin
			cf1 = c[1:0];
			cf2 = 2'h3 - c[1:0];
			push(12'h5A3, 1'b1);
			data({cb(cf2, 1'b0), cb(cf1, 1'b1), 12'h5A3});
		end
		$display("test config done");
	endtask : t_cfg
	task automatic t_trig;
		mode = 1'b0;
		push(12'h123, 1'b0);
		rx.pulse_sync();
		chk("busy", {15'h0, busy}, 16'h0);
		data({cb(cf2, 1'b1), cb(cf1, 1'b0), 12'h123});
		mode = 1'b1;
		$display("test trigger done");
	endtask : t_trig
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		end_of_test();
	end
	initial begin
		{rst, valid, en, mode, aux1, aux2, smp, cf1, cf2} = {4'h9, 18'h0};
		n_errors = 0;
		checked = 0;
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		chk("frame", frm, 16'h0);
		chk("busy", {15'h0, busy}, 16'h0);
		chk("ready", {15'h0, rdy}, 16'h1);
		step(1'b0, 16'h0);
		t_sync();
		t_fill();
		t_cfg();
		t_trig();
		t_sync();
		t_cfg();
		chk("clock_bit_error", {15'h0, cerr}, 16'h0);
		end_of_test();
	end
endmodule : slse_encoder_test
`default_nettype wire
